// ==== pkg/ext_alu_pkg.sv ====
// Shared constants, encodings and helpers for the extended rotate/skip datapath
package ext_alu_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] ACC_OFS = 12'h000;
  localparam logic [APB_ADDR_W-1:0] FLAGS_OFS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] CTRL_OFS = 12'h008;
  localparam logic [APB_ADDR_W-1:0] LAST_OFS = 12'h00c;

  // ==========================================================================
  // Field positions and reset values
  localparam int FLAG_W = 6;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_AC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  localparam int FLAG_SC_BIT = 4;
  localparam int FLAG_CZ_BIT = 5;
  localparam logic [FLAG_W-1:0] FLAG_NONE_MASK = 6'h00;
  localparam logic [FLAG_W-1:0] FLAG_C_MASK = 6'h01;
  localparam logic [FLAG_W-1:0] FLAG_SUB_MASK = 6'h3f;
  localparam int CTRL_EN_BIT = 0;
  localparam int LAST_SKIP_BIT = 8;
  localparam int LAST_ILL_BIT = 9;
  localparam int LAST_BUSY_BIT = 10;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // ==========================================================================
  // Operation codes presented by the sequencer
  typedef enum logic [4:0] {
    op_rotate_left_mem = 5'h00,
    op_rotate_left_to_acc = 5'h01,
    op_rotate_left_thru_carry_mem = 5'h02,
    op_rotate_left_thru_carry_to_acc = 5'h03,
    op_rotate_right_mem = 5'h04,
    op_rotate_right_to_acc = 5'h05,
    op_rotate_right_thru_carry_mem = 5'h06,
    op_rotate_right_thru_carry_to_acc = 5'h07,
    op_subtract_borrow_to_acc = 5'h08,
    op_subtract_borrow_to_mem = 5'h09,
    op_subtract_to_acc = 5'h0a,
    op_subtract_to_mem = 5'h0b,
    op_decrement_skip_zero_mem = 5'h0c,
    op_decrement_skip_zero_to_acc = 5'h0d,
    op_increment_skip_zero_mem = 5'h0e,
    op_increment_skip_zero_to_acc = 5'h0f,
    op_set_all_bits = 5'h10,
    op_set_one_bit = 5'h11,
    op_skip_if_nonzero = 5'h12,
    op_skip_if_bit_nonzero = 5'h13,
    op_skip_if_zero = 5'h14,
    op_move_and_skip_if_zero = 5'h15,
    op_nibble_exchange_mem = 5'h16,
    op_nibble_exchange_to_acc = 5'h17
  } op_e;

  // Sequencing states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_fetch = 2'b01,
    st_exec = 2'b10,
    st_dummy = 2'b11
  } state_e;

  // ==========================================================================
  // Helpers
  function automatic logic byte_is_zero(input logic [7:0] value);
    return (value == 8'h00);
  endfunction : byte_is_zero

  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    return BYTE_ONE << sel;
  endfunction : bit_mask

  function automatic logic op_uses_borrow(input op_e op);
    return (op == op_subtract_borrow_to_acc) || (op == op_subtract_borrow_to_mem);
  endfunction : op_uses_borrow

endpackage : ext_alu_pkg

// ==== core/sub_flag_calc.sv ====
// Subtractor with full arithmetic flag generation
`timescale 1ns/1ps
module sub_flag_calc (
  input wire logic [7:0] minuend, // Accumulator value
  input wire logic [7:0] subtrahend, // Memory byte
  input wire logic borrow_in, // Inverted carry for borrow forms, else 0
  input wire logic chain, // Borrow form: zero flag chains with previous
  input wire logic cz_in, // Previous chained-zero flag
  output logic [7:0] result, // Difference
  output logic [ext_alu_pkg::FLAG_W-1:0] flags // Flags after the subtract
);
  import ext_alu_pkg::*;

  // ==========================================================================
  // Arithmetic
  logic [8:0] full;
  logic [4:0] low;
  logic ov;
  logic zero;

  // Ninth bit of the difference is the borrow out
  assign full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
  assign ov = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
  assign zero = byte_is_zero(full[7:0]);
  assign result = full[7:0];

  // Carry reads as not-borrow: cleared on a negative result
  always_comb begin
    flags = FLAGS_RST;
    flags[FLAG_C_BIT] = ~full[8]; // RULE8
    flags[FLAG_AC_BIT] = ~low[4]; // RULE9
    flags[FLAG_Z_BIT] = zero; // RULE9
    flags[FLAG_OV_BIT] = ov; // RULE9
    flags[FLAG_SC_BIT] = full[7] ^ ov; // RULE9
    flags[FLAG_CZ_BIT] = chain ? (zero & cz_in) : zero; // RULE9
  end

endmodule : sub_flag_calc

// ==== core/ext_alu_unit.sv ====
// Combinational operation decode and result selection
`timescale 1ns/1ps
module ext_alu_unit (
  input wire ext_alu_pkg::op_e op, // Operation being executed
  input wire logic [7:0] mem_byte, // Byte read from data memory
  input wire logic carry, // Current carry flag
  input wire logic [2:0] bitsel, // Bit index for bit forms
  input wire logic [7:0] sub_result, // Difference from the subtractor
  input wire logic [ext_alu_pkg::FLAG_W-1:0] sub_flags, // Subtractor flags
  output logic [7:0] result, // Value to write
  output logic to_mem, // Result goes back to memory
  output logic to_acc, // Result goes to the accumulator
  output logic [ext_alu_pkg::FLAG_W-1:0] flag_mask, // Flags that change
  output logic [ext_alu_pkg::FLAG_W-1:0] flag_val, // New flag values
  output logic skip, // Skip the following instruction
  output logic illegal // Unknown operation code
);
  import ext_alu_pkg::*;

  // ==========================================================================
  // Result selection
  logic [7:0] dec_val;
  logic [7:0] inc_val;

  assign dec_val = mem_byte - BYTE_ONE;
  assign inc_val = mem_byte + BYTE_ONE;

  // Unknown codes only raise illegal rather than guess at a neighbour
  // Paired forms except subtract: even code writes memory, odd code the accumulator
  always_comb begin
    result = mem_byte;
    to_mem = 1'b0;
    to_acc = 1'b0;
    flag_mask = FLAG_NONE_MASK;
    flag_val = sub_flags;
    skip = 1'b0;
    illegal = 1'b0;
    case (op)
      op_rotate_left_mem, op_rotate_left_to_acc: begin
        result = {mem_byte[6:0], mem_byte[7]}; // RULE1
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE5
      end
      op_rotate_left_thru_carry_mem, op_rotate_left_thru_carry_to_acc: begin
        result = {mem_byte[6:0], carry}; // RULE2
        flag_mask = FLAG_C_MASK;
        flag_val[FLAG_C_BIT] = mem_byte[7]; // RULE2
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE5
      end
      op_rotate_right_mem, op_rotate_right_to_acc: begin
        result = {mem_byte[0], mem_byte[7:1]}; // RULE3
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE5
      end
      op_rotate_right_thru_carry_mem, op_rotate_right_thru_carry_to_acc: begin
        result = {carry, mem_byte[7:1]}; // RULE4
        flag_mask = FLAG_C_MASK;
        flag_val[FLAG_C_BIT] = mem_byte[0]; // RULE4
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE5
      end
      op_subtract_borrow_to_acc, op_subtract_borrow_to_mem,
      op_subtract_to_acc, op_subtract_to_mem: begin
        result = sub_result; // RULE6 RULE7
        flag_mask = FLAG_SUB_MASK; // RULE9
        to_mem = (op == op_subtract_borrow_to_mem) || (op == op_subtract_to_mem);
        to_acc = (op == op_subtract_borrow_to_acc) || (op == op_subtract_to_acc);
      end
      op_decrement_skip_zero_mem, op_decrement_skip_zero_to_acc: begin
        result = dec_val; // RULE10
        skip = byte_is_zero(dec_val); // RULE10 RULE12
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE12
      end
      op_increment_skip_zero_mem, op_increment_skip_zero_to_acc: begin
        result = inc_val; // RULE11
        skip = byte_is_zero(inc_val); // RULE11 RULE12
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE12
      end
      op_set_all_bits: begin
        result = BYTE_ONES; // RULE14
        to_mem = 1'b1;
      end
      op_set_one_bit: begin
        result = mem_byte | bit_mask(bitsel); // RULE15
        to_mem = 1'b1;
      end
      op_skip_if_nonzero: skip = ~byte_is_zero(mem_byte); // RULE16
      op_skip_if_bit_nonzero: skip = ~byte_is_zero(mem_byte & bit_mask(bitsel)); // RULE16
      op_skip_if_zero: skip = byte_is_zero(mem_byte); // RULE17
      op_move_and_skip_if_zero: begin
        to_acc = 1'b1; // RULE18
        skip = byte_is_zero(mem_byte); // RULE18
      end
      op_nibble_exchange_mem, op_nibble_exchange_to_acc: begin
        result = {mem_byte[3:0], mem_byte[7:4]}; // RULE19
        {to_acc, to_mem} = {op[0], ~op[0]}; // RULE20
      end
      default: illegal = 1'b1;
    endcase
  end

endmodule : ext_alu_unit

// ==== core/extended_rotate_skip_alu.sv ====
// Extended-instruction execution block: rotate, subtract, skip, set, swap
//
// Summary of operation
// (RULE1) Left rotate: bit 7 into bit 0
// (RULE2) Left through carry: carry in, bit 7 out
// (RULE3) Right rotate: bit 0 into bit 7
// (RULE4) Right through carry: carry in, bit 0 out
// (RULE5) Accumulator forms leave memory byte unchanged
// (RULE6) Borrow subtract: acc minus mem minus not-carry
// (RULE7) Plain subtract: acc minus mem, either destination
// (RULE8) Subtract carry clear when negative, else set
// (RULE9) Subtract updates all six arithmetic flags
// (RULE10) Decrement, write back, skip on zero
// (RULE11) Increment, write back, skip on zero
// (RULE12) Accumulator inc/dec forms skip on accumulator zero
// (RULE13) Skip takes two cycles with dummy
// (RULE14) Byte set writes all ones, no flags
// (RULE15) Bit set forces one chosen bit only
// (RULE16) Non-zero test skips on byte or bit
// (RULE17) Zero test skips, changes nothing
// (RULE18) Move to accumulator and skip on zero
// (RULE19) Nibble swap in place, no flags
// (RULE20) Accumulator nibble swap leaves memory unchanged
// (RULE21) Full address reaches any memory section
// (RULE22) Dummy cycle suppresses discarded instruction writes
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module extended_rotate_skip_alu #(
  parameter int MEM_ADDR_W = 12 // Full data memory address, section bits included
) (
  input wire logic pclk, // Clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ext_alu_pkg::APB_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic ex_valid, // Sequencer presents an instruction
  input wire ext_alu_pkg::op_e ex_op, // Operation code
  input wire logic [MEM_ADDR_W-1:0] ex_addr, // Operand address
  input wire logic [2:0] ex_bit, // Bit index for bit forms
  output logic ex_ready, // Instruction is taken when valid and ready
  output logic ex_done, // Execution finished, one cycle
  output logic skip_taken, // Next instruction is to be skipped, one cycle
  output logic dummy_cycle, // Dummy slot in progress
  output logic discarded, // Skipped instruction absorbed, one cycle
  output logic mem_rd_en, // Memory read strobe
  output logic mem_wr_en, // Memory write strobe
  output logic [MEM_ADDR_W-1:0] mem_addr, // Memory address
  output logic [7:0] mem_wdata, // Memory write data
  input wire logic [7:0] mem_rdata, // Read data, valid cycle after strobe
  output logic [7:0] acc_value, // Accumulator
  output logic [ext_alu_pkg::FLAG_W-1:0] flag_value // Status flags
);
  import ext_alu_pkg::*;

  // ==========================================================================
  // State record
  typedef struct packed {
    state_e state;
    logic ready;
    logic done;
    logic skip;
    logic dummy;
    logic discard;
    logic busy;
    logic rd_en;
    logic wr_en;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    op_e op;
    logic [2:0] bitsel;
    logic [7:0] acc;
    logic [FLAG_W-1:0] flags;
    logic enable;
    logic [7:0] last_res;
    logic last_skip;
    logic last_illegal;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } regs_s;

  regs_s r_ff;
  regs_s nxt_r;

  // ==========================================================================
  // Datapath
  logic [7:0] sub_res;
  logic [FLAG_W-1:0] sub_flags;
  logic [7:0] u_result;
  logic u_to_mem;
  logic u_to_acc;
  logic [FLAG_W-1:0] u_mask;
  logic [FLAG_W-1:0] u_flags;
  logic u_skip;
  logic u_illegal;

  // Borrow forms feed the inverted carry as borrow
  sub_flag_calc u_sub (
    .minuend(r_ff.acc),
    .subtrahend(mem_rdata),
    .borrow_in(op_uses_borrow(r_ff.op) & ~r_ff.flags[FLAG_C_BIT]), // RULE6
    .chain(op_uses_borrow(r_ff.op)),
    .cz_in(r_ff.flags[FLAG_CZ_BIT]),
    .result(sub_res),
    .flags(sub_flags)
  );

  ext_alu_unit u_unit (
    .op(r_ff.op),
    .mem_byte(mem_rdata),
    .carry(r_ff.flags[FLAG_C_BIT]),
    .bitsel(r_ff.bitsel),
    .sub_result(sub_res),
    .sub_flags(sub_flags),
    .result(u_result),
    .to_mem(u_to_mem),
    .to_acc(u_to_acc),
    .flag_mask(u_mask),
    .flag_val(u_flags),
    .skip(u_skip),
    .illegal(u_illegal)
  );

  // ==========================================================================
  // Next-state logic
  logic apb_setup;
  logic apb_done;
  logic addr_ok;
  logic [31:0] rd_word;

  // One wait state on every APB access keeps prdata and pready registered
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.skip = 1'b0;
    nxt_r.discard = 1'b0;
    nxt_r.rd_en = 1'b0;
    nxt_r.wr_en = 1'b0;
    apb_setup = psel & penable & ~r_ff.pready;
    apb_done = psel & penable & r_ff.pready;
    case (paddr)
      ACC_OFS: rd_word = {24'h000000, r_ff.acc};
      FLAGS_OFS: rd_word = {26'h0000000, r_ff.flags};
      CTRL_OFS: rd_word = {31'h00000000, r_ff.enable};
      LAST_OFS: begin
        rd_word = {21'h000000, r_ff.busy, r_ff.last_illegal, r_ff.last_skip, r_ff.last_res};
        addr_ok = ~pwrite;
      end
      default: addr_ok = 1'b0;
    endcase
    nxt_r.pready = apb_setup;
    nxt_r.pslverr = apb_setup & ~addr_ok;
    nxt_r.prdata = (apb_setup & ~pwrite & addr_ok) ? rd_word : 32'h0000_0000;
    // Software writes land first so execution below overrides them
    if (apb_done & pwrite) begin
      case (paddr)
        ACC_OFS: nxt_r.acc = pwdata[7:0];
        FLAGS_OFS: nxt_r.flags = pwdata[FLAG_W-1:0];
        CTRL_OFS: nxt_r.enable = pwdata[CTRL_EN_BIT];
        default: nxt_r.enable = r_ff.enable;
      endcase
    end
    unique case (r_ff.state)
      st_idle: begin
        if (ex_valid && r_ff.ready) begin
          nxt_r.op = ex_op;
          nxt_r.addr = ex_addr; // RULE21
          nxt_r.bitsel = ex_bit;
          nxt_r.rd_en = 1'b1;
          nxt_r.ready = 1'b0;
          nxt_r.state = st_fetch;
        end else begin
          nxt_r.ready = nxt_r.enable;
        end
      end
      st_fetch: nxt_r.state = st_exec;
      st_exec: begin
        nxt_r.done = 1'b1;
        nxt_r.skip = u_skip;
        nxt_r.last_res = u_result;
        nxt_r.last_skip = u_skip;
        nxt_r.last_illegal = u_illegal;
        if (u_to_mem) begin
          nxt_r.wr_en = 1'b1; // RULE5
          nxt_r.wdata = u_result;
        end
        if (u_to_acc) begin
          nxt_r.acc = u_result;
        end
        // Only flags the operation owns change; the rest keep any software write
        nxt_r.flags = (nxt_r.flags & ~u_mask) | (u_flags & u_mask); // RULE8 RULE9
        if (u_skip) begin
          nxt_r.state = st_dummy; // RULE13
          nxt_r.dummy = 1'b1;
          nxt_r.ready = 1'b1;
        end else begin
          nxt_r.state = st_idle; // RULE13
          nxt_r.ready = nxt_r.enable;
        end
      end
      st_dummy: begin
        // The skipped instruction is taken and dropped with no write of any kind
        if (ex_valid && r_ff.ready) begin
          nxt_r.discard = 1'b1; // RULE22
          nxt_r.dummy = 1'b0;
          nxt_r.state = st_idle;
          nxt_r.ready = nxt_r.enable;
        end
      end
    endcase
    nxt_r.busy = (nxt_r.state != st_idle);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{default: '0, state: st_idle, op: op_rotate_left_mem, acc: ACC_RST,
                flags: FLAGS_RST, enable: CTRL_EN_RST};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign ex_ready = r_ff.ready;
  assign ex_done = r_ff.done;
  assign skip_taken = r_ff.skip;
  assign dummy_cycle = r_ff.dummy;
  assign discarded = r_ff.discard;
  assign mem_rd_en = r_ff.rd_en;
  assign mem_wr_en = r_ff.wr_en;
  assign mem_addr = r_ff.addr;
  assign mem_wdata = r_ff.wdata;
  assign acc_value = r_ff.acc;
  assign flag_value = r_ff.flags;

endmodule : extended_rotate_skip_alu

// ==== tb/data_mem_model.sv ====
// Behavioural data memory that answers the block's operand reads
`timescale 1ns/1ps
module data_mem_model #(
  parameter int AW = 12 // Address width, all sections
) (
  input wire logic clk, // Clock
  input wire logic rd_en, // Read strobe
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata // Read data
);
  logic [7:0] mem [2**AW];
  logic [7:0] q = 8'h00;
  assign rdata = q;
  // ==========================================================================
  // Access
  // Data flips after its one valid cycle, so a late sample fails
  always @(posedge clk) begin
    if (rd_en) begin
      q <= mem[addr];
    end else begin
      q <= ~q;
    end
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end
endmodule : data_mem_model

// ==== tb/ext_alu_checker_properties.sv ====
// Checker of timing and results at the execution block's ports
`timescale 1ns/1ps
module ext_alu_checker #(
  parameter int MEM_ADDR_W = 12 // Memory address width
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic ex_valid, // Instruction valid
  input wire ext_alu_pkg::op_e ex_op, // Operation
  input wire logic [MEM_ADDR_W-1:0] ex_addr, // Operand address
  input wire logic ex_ready, // Ready to take
  input wire logic ex_done, // Finished pulse
  input wire logic skip_taken, // Skip pulse
  input wire logic dummy_cycle, // Dummy slot
  input wire logic discarded, // Absorbed pulse
  input wire logic mem_rd_en, // Read strobe
  input wire logic mem_wr_en, // Write strobe
  input wire logic [MEM_ADDR_W-1:0] mem_addr, // Memory address
  input wire logic [7:0] mem_wdata, // Write data
  input wire logic [7:0] mem_rdata, // Read data
  input wire logic [7:0] acc_value // Accumulator
);
  import ext_alu_pkg::*;
  op_e op_q;
  logic rd_d;
  logic [7:0] rd_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Helper: operation and operand byte of the instruction in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= op_rotate_left_mem;
      rd_d <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      if (ex_valid && ex_ready && !dummy_cycle) begin
        op_q <= ex_op;
      end
      rd_d <= mem_rd_en;
      if (rd_d) begin
        rd_q <= mem_rdata;
      end
    end
  end
  // ==========================================================================
  // Assertions
  AST_TAKE_READ: assert property (
    ex_valid && ex_ready && !dummy_cycle |=> mem_rd_en && mem_addr == $past(ex_addr))
    else $error("operand read missing after take");
  AST_DONE_LAT: assert property (mem_rd_en |=> ##1 ex_done)
    else $error("done not two cycles after read");
  AST_SKIP_DUMMY: assert property (skip_taken |-> ex_done && dummy_cycle)
    else $error("skip without done and dummy slot");
  AST_DISCARD_QUIET: assert property (
    discarded |-> $past(dummy_cycle) && !dummy_cycle && !mem_wr_en && !mem_rd_en)
    else $error("discarded instruction had effect");
  AST_ROL: assert property (ex_done && op_q == op_rotate_left_mem |->
    mem_wr_en && mem_wdata == {rd_q[6:0], rd_q[7]}) else $error("left rotate wrong");
  AST_RORA: assert property (ex_done && op_q == op_rotate_right_to_acc |->
    !mem_wr_en && acc_value == {rd_q[0], rd_q[7:1]}) else $error("right rotate wrong");
  AST_SET: assert property (ex_done && op_q == op_set_all_bits |->
    mem_wr_en && mem_wdata == 8'hff) else $error("byte set wrong");
  AST_SWAP: assert property (ex_done && op_q == op_nibble_exchange_mem |->
    mem_wr_en && mem_wdata == {rd_q[3:0], rd_q[7:4]}) else $error("swap wrong");
  AST_DEC: assert property (ex_done && op_q == op_decrement_skip_zero_mem |->
    mem_wdata == rd_q - 8'h01 && skip_taken == (rd_q == 8'h01)) else $error("dec wrong");
  AST_ZTEST: assert property (ex_done && op_q == op_skip_if_zero |->
    !mem_wr_en && skip_taken == (rd_q == 8'h00)) else $error("zero test wrong");
  COV_SKIP: cover property (skip_taken);
  COV_DISCARD: cover property (discarded);
  COV_PLAIN: cover property (ex_done && !skip_taken);
endmodule : ext_alu_checker
bind extended_rotate_skip_alu ext_alu_checker #(.MEM_ADDR_W(MEM_ADDR_W)) i_ext_alu_checker (.*);

// ==== tb/tb_extended_rotate_skip_alu.sv ====
// Self-checking bench for the extended rotate/skip execution block
`timescale 1ns/1ps
module tb_extended_rotate_skip_alu;
  import ext_alu_pkg::*;
  localparam logic [23:0] TO_MEM = 24'h435a55;
  localparam logic [23:0] TO_ACC = 24'ha0a5aa;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ex_ready, ex_done, skip_taken, dummy_cycle, discarded;
  logic ex_valid = 1'b0;
  op_e ex_op = op_rotate_left_mem;
  logic [11:0] ex_addr = 12'h000;
  logic [2:0] ex_bit = 3'h0;
  logic mem_rd_en, mem_wr_en;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, acc_value;
  logic [5:0] flag_value;
  int fail_count = 0;
  int checks = 0;
  extended_rotate_skip_alu i_extended_rotate_skip_alu (.*);
  data_mem_model i_data_mem_model (.clk(pclk), .rd_en(mem_rd_en), .wr_en(mem_wr_en),
    .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));
  // ==========================================================================
  // Clock and watchdog
  initial begin
    forever #50 pclk = ~pclk;
  end
  initial begin
    #1_000_000;
    fail_count++;
    conclude();
  end
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Bus cycle: one idle edge first, so psel never changes twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_count++;
  endtask : apb
  task automatic issue(input op_e op, input logic [11:0] ad, input logic [2:0] b);
    int n = 0;
    @(posedge pclk);
    ex_valid <= 1'b1;
    ex_op <= op;
    ex_addr <= ad;
    ex_bit <= b;
    do begin
      @(posedge pclk);
      n++;
    end while (ex_ready !== 1'b1 && n < 20);
    ex_valid <= 1'b0;
    if (n >= 20) fail_count++;
  endtask : issue
  // Expected result, skip and flags of one instruction
  function automatic void predict(input op_e op, input logic [7:0] m, a, input logic [5:0] f,
      input logic [2:0] b, output logic [7:0] r, output logic sk, output logic [5:0] nf);
    logic [8:0] d;
    logic [4:0] h;
    logic bc, bw, ov, z;
    bc = op_uses_borrow(op);
    bw = bc & ~f[0];
    d = {1'b0, a} - {1'b0, m} - {8'h00, bw};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bw};
    ov = (a[7] ^ m[7]) & (a[7] ^ d[7]);
    z = (d[7:0] == 8'h00);
    nf = f;
    sk = 1'b0;
    r = d[7:0];
    case (op)
      op_rotate_left_mem, op_rotate_left_to_acc: r = {m[6:0], m[7]};
      op_rotate_left_thru_carry_mem, op_rotate_left_thru_carry_to_acc: begin
        r = {m[6:0], f[0]};
        nf[0] = m[7];
      end
      op_rotate_right_mem, op_rotate_right_to_acc: r = {m[0], m[7:1]};
      op_rotate_right_thru_carry_mem, op_rotate_right_thru_carry_to_acc: begin
        r = {f[0], m[7:1]};
        nf[0] = m[0];
      end
      op_subtract_borrow_to_acc, op_subtract_borrow_to_mem, op_subtract_to_acc,
      op_subtract_to_mem: nf = {z & (f[5] | ~bc), d[7] ^ ov, ov, z, ~h[4], ~d[8]};
      op_decrement_skip_zero_mem, op_decrement_skip_zero_to_acc: r = m - 8'h01;
      op_increment_skip_zero_mem, op_increment_skip_zero_to_acc: r = m + 8'h01;
      op_set_all_bits: r = 8'hff;
      op_set_one_bit: r = m | (8'h01 << b);
      op_skip_if_nonzero: sk = (m != 8'h00);
      op_skip_if_bit_nonzero: sk = m[b];
      op_skip_if_zero: sk = (m == 8'h00);
      op_move_and_skip_if_zero: r = m;
      op_nibble_exchange_mem, op_nibble_exchange_to_acc: r = {m[3:0], m[7:4]};
      default: r = m;
    endcase
    if (op inside {[op_decrement_skip_zero_mem:op_increment_skip_zero_to_acc],
        op_move_and_skip_if_zero}) sk = (r == 8'h00);
  endfunction : predict
  // One instruction with its operand preset, then the dummy slot if skipping
  task automatic run_op(input op_e op, input logic [11:0] ad, input logic [7:0] m, a,
      input logic [5:0] f, input logic [2:0] b);
    logic [31:0] rd;
    logic err, sk;
    logic [7:0] r, ea;
    logic [5:0] nf;
    int n = 0;
    predict(op, m, a, f, b, r, sk, nf);
    ea = TO_ACC[op] ? r : a;
    i_data_mem_model.mem[ad] = m;
    i_data_mem_model.mem[ad ^ 12'h800] = 8'h5a;
    apb(1'b1, ACC_OFS, {24'h0, a}, rd, err);
    apb(1'b1, FLAGS_OFS, {26'h0, f}, rd, err);
    issue(op, ad, b);
    do begin
      @(negedge pclk);
      n++;
    end while (ex_done !== 1'b1 && n < 10);
    check("ex_done", ex_done, 32'(n == 3));
    check("mem_wr_en", mem_wr_en, 32'(TO_MEM[op]));
    if (TO_MEM[op]) check("mem_wdata", mem_wdata, r);
    check("skip_taken", skip_taken, sk);
    check("acc", acc_value, ea);
    check("flags", flag_value, nf);
    if (sk) begin
      issue(op_set_all_bits, ad ^ 12'h800, 3'h0);
      @(negedge pclk);
      check("discarded", discarded, 1'b1);
      repeat (4) @(negedge pclk);
      check("slot mem", i_data_mem_model.mem[ad ^ 12'h800], 8'h5a);
      check("slot acc", acc_value, ea);
    end
    repeat (2) @(negedge pclk);
    check("mem", i_data_mem_model.mem[ad], TO_MEM[op] ? r : m);
  endtask : run_op
  // ==========================================================================
  // Main sequence: register access, then every operation on corner bytes
  initial begin
    logic [31:0] rd;
    logic err;
    logic [7:0] m;
    void'($urandom(32'h42f8));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACC_OFS, 32'h0, rd, err);
    check("acc reset", rd, {24'h0, ACC_RST});
    apb(1'b0, 12'h010, 32'h0, rd, err);
    check("unmapped error", err, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      for (int k = 0; k < 4; k++) begin
        m = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'hff : 8'($urandom);
        run_op(op_e'(i), 12'($urandom), m, 8'($urandom), 6'($urandom), 3'($urandom));
      end
      $display("test op %0d done", i);
    end
    // Disable stops intake; read-only register refuses writes
    apb(1'b1, CTRL_OFS, 32'h0, rd, err);
    @(negedge pclk);
    check("ready off", ex_ready, 1'b0);
    apb(1'b1, LAST_OFS, 32'h0, rd, err);
    check("ro error", err, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h1, rd, err);
    $display("test control done");
    conclude();
  end
endmodule : tb_extended_rotate_skip_alu
